/* core/cmma_mem.sv */
`timescale 1ns/100ps
module cmma_mem (
  // Clock
  input wire logic ref_clk_i,
  // Port
  input wire logic we_i,
  input wire logic [9:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [cmma_pkg::MEM_WORDS];
  logic [15:0] rdata_reg;

  // Factory image: all clear apart from pin functions and checksum
  initial begin
    for (int i = 0; i < cmma_pkg::MEM_WORDS; i++) begin
      mem[i] = 16'h0000;
    end
    mem[cmma_pkg::W_PINFN] = cmma_pkg::PINFN_RST;
    mem[cmma_pkg::W_CSUM] = cmma_pkg::CSUM_RST;
  end

  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_reg <= mem[addr_i];
  end

  assign rdata_o = rdata_reg;
endmodule

/* core/cmma_pinmux.sv */
`timescale 1ns/100ps
module cmma_pinmux (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Configuration
  input wire logic [15:0] pinfn_i,
  // Sources
  input wire logic suspend_i,
  input wire logic rs485_tx_enable_i,
  input wire logic rx_act_i,
  input wire logic tx_act_i,
  // Pins
  output logic [3:0] pin_o,
  output logic [3:0] pin_oe_o
);
  logic [3:0] pin_reg;
  logic [3:0] pin_next;
  logic [3:0] oe_reg;
  logic [3:0] oe_next;

  for (genvar g = 0; g < 4; g++) begin : g_pin
    logic p;
    logic oe;
    always_comb begin
      p = 1'b0;
      oe = 1'b0;
      // LEDs sink current only; idle is released, not driven high
      case (pinfn_i[4*g +: 4])
        cmma_pkg::FN_RS485_EN: begin
          p = rs485_tx_enable_i;
          oe = 1'b1;
        end
        cmma_pkg::FN_RX_LED: oe = rx_act_i;
        cmma_pkg::FN_TX_LED: oe = tx_act_i;
        cmma_pkg::FN_ANY_LED: oe = rx_act_i | tx_act_i;
        cmma_pkg::FN_SLEEP: begin
          p = ~suspend_i;
          oe = 1'b1;
        end
        cmma_pkg::FN_LOW: oe = 1'b1;
        cmma_pkg::FN_HIGH: begin
          p = 1'b1;
          oe = 1'b1;
        end
        default: oe = 1'b0;
      endcase
    end
    assign pin_next[g] = p;
    assign oe_next[g] = oe;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pin_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else begin
      pin_reg <= pin_next;
      oe_reg <= oe_next;
    end
  end

  assign pin_o = pin_reg;
  assign pin_oe_o = oe_reg;
endmodule

/* core/cmma_pkg.sv */
package cmma_pkg;
  localparam int unsigned MEM_AW = 10;
  localparam int unsigned MEM_DW = 16;
  localparam int unsigned MEM_WORDS = 1024;

  // Bus register byte offsets
  localparam logic [7:0] A_ADDR = 8'h00;
  localparam logic [7:0] A_DATA = 8'h04;
  localparam logic [7:0] A_CMD = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_CFG = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned CMD_READ = 0;
  localparam int unsigned CMD_RELOAD = 1;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DONE = 1;
  localparam int unsigned ST_CSUM = 2;
  localparam int unsigned ST_REJ = 3;

  // Memory map, word addresses
  localparam logic [9:0] CFG1_LO = 10'h000;
  localparam logic [9:0] CFG1_HI = 10'h010;
  localparam logic [9:0] USER1_LO = 10'h012;
  localparam logic [9:0] USER1_HI = 10'h03e;
  localparam logic [9:0] RSV_LO = 10'h040;
  localparam logic [9:0] RSV_HI = 10'h04e;
  localparam logic [9:0] CFG2_LO = 10'h050;
  localparam logic [9:0] CFG2_HI = 10'h07e;
  localparam logic [9:0] USER2_LO = 10'h080;
  localparam logic [9:0] USER2_HI = 10'h3ff;
  localparam logic [9:0] W_PINFN = 10'h00a;
  localparam logic [9:0] W_INV = 10'h00b;
  localparam logic [9:0] W_CSUM = 10'h07e;
  localparam int unsigned LOAD_CYCLES = 2 * (int'(W_CSUM) + 1);

  // Pin function codes, one nibble per pin
  localparam logic [3:0] FN_TRI = 4'h0;
  localparam logic [3:0] FN_RS485_EN = 4'h1;
  localparam logic [3:0] FN_RX_LED = 4'h2;
  localparam logic [3:0] FN_TX_LED = 4'h3;
  localparam logic [3:0] FN_SLEEP = 4'h4;
  localparam logic [3:0] FN_ANY_LED = 4'h5;
  localparam logic [3:0] FN_LOW = 4'h6;
  localparam logic [3:0] FN_HIGH = 4'h7;

  localparam int unsigned INV_TXD = 0;
  localparam int unsigned INV_RXD = 1;
  localparam int unsigned INV_RTS = 2;
  localparam int unsigned INV_CTS = 3;
  localparam int unsigned INV_DTR = 4;
  localparam int unsigned INV_DSR = 5;
  localparam int unsigned INV_DCD = 6;
  localparam int unsigned INV_RI = 7;

  localparam logic [15:0] PINFN_RST = 16'h4321;
  localparam logic [7:0] INV_RST = 8'h00;
  localparam logic [15:0] CSUM_RST = 16'h4321;

  typedef enum logic [1:0] {S_IDLE, S_HRD, S_LRD, S_LACC} cmma_state_t;

  function automatic logic in_cfg(input logic [9:0] a);
    return (a <= CFG1_HI) || (a >= CFG2_LO && a <= CFG2_HI);
  endfunction

  function automatic logic wr_ok(input logic [9:0] a);
    return in_cfg(a) || (a >= USER1_LO && a <= USER1_HI) || (a >= USER2_LO);
  endfunction
endpackage

/* core/cmma_top.sv */
`timescale 1ns/100ps
// Overview of operation
// - Default pins: RS485 enable, RX LED, TX LED
// - Default fourth pin low while suspended
// - Optional inversion of serial transmit and receive
// - Separate inversion for each modem control line
// - User areas freely read, written, not summed
// - Writable config areas covered by checksum
// - Reserved words refuse every write attempt
// - Pin functions and line inversions come from config
// - Reload configuration after power-on and USB reset
module cmma_top (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // USB core
  input wire logic usb_reset_i,
  input wire logic usb_suspend_i,
  // UART core side
  input wire logic core_txd_i,
  output logic core_rxd_o,
  input wire logic core_rts_n_i,
  input wire logic core_dtr_n_i,
  output logic core_cts_n_o,
  output logic core_dsr_n_o,
  output logic core_dcd_n_o,
  output logic core_ri_n_o,
  input wire logic core_rs485_tx_enable_i,
  input wire logic core_rx_act_i,
  input wire logic core_tx_act_i,
  // UART pins
  output logic txd_o,
  input wire logic rxd_i,
  output logic rts_o,
  output logic dtr_o,
  input wire logic cts_i,
  input wire logic dsr_i,
  input wire logic dcd_i,
  input wire logic ri_i,
  // Configurable pins
  output logic [3:0] config_pin_group_o,
  output logic [3:0] config_pin_group_oe_o
);
  cmma_pkg::cmma_state_t state_reg, state_next;
  logic [9:0] scan_reg, scan_next;
  logic [15:0] sum_reg, sum_next;
  logic [15:0] pinfn_reg, pinfn_next;
  logic [7:0] inv_reg, inv_next;
  logic done_reg, done_next;
  logic csum_reg, csum_next;
  logic rej_reg, rej_next;
  logic [9:0] addr_reg, addr_next;
  logic [15:0] rdbuf_reg, rdbuf_next;
  logic aw_hold_reg, aw_hold_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic w_hold_reg, w_hold_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [8:0] ld_cyc_reg, ld_cyc_next;
  logic mem_we;
  logic [9:0] mem_addr;
  logic [15:0] mem_rdata;
  logic busy;
  logic load_busy;
  logic do_wr;

  assign busy = (state_reg != cmma_pkg::S_IDLE);
  assign load_busy = (state_reg == cmma_pkg::S_LRD) || (state_reg == cmma_pkg::S_LACC);
  assign do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign s_axi_awready_o = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready_o = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign mem_addr = (state_reg == cmma_pkg::S_LRD) ? scan_reg : addr_reg;

  always_comb begin
    logic start_load;
    start_load = 1'b0;
    state_next = state_reg;
    scan_next = scan_reg;
    sum_next = sum_reg;
    pinfn_next = pinfn_reg;
    inv_next = inv_reg;
    done_next = done_reg;
    csum_next = csum_reg;
    rej_next = rej_reg;
    addr_next = addr_reg;
    rdbuf_next = rdbuf_reg;
    aw_hold_next = aw_hold_reg;
    awaddr_next = awaddr_reg;
    w_hold_next = w_hold_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    ld_cyc_next = ld_cyc_reg;
    mem_we = 1'b0;

    // Address and data are held separately, so either may come first
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_hold_next = 1'b1;
      awaddr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_hold_next = 1'b1;
      wdata_next = s_axi_wdata_i;
      wstrb_next = s_axi_wstrb_i;
    end
    if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end

    if (do_wr) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = cmma_pkg::RESP_OKAY;
      case (awaddr_reg)
        cmma_pkg::A_ADDR: begin
          if (wstrb_reg[0]) begin
            addr_next[7:0] = wdata_reg[7:0];
          end
          if (wstrb_reg[1]) begin
            addr_next[9:8] = wdata_reg[9:8];
          end
        end
        cmma_pkg::A_DATA: begin
          if (busy || wstrb_reg[1:0] != 2'h3) begin
            bresp_next = cmma_pkg::RESP_SLVERR;
          end else if (cmma_pkg::wr_ok(addr_reg)) begin
            mem_we = 1'b1;
          end else begin
            // Reserved or unlisted word: contents untouched
            rej_next = 1'b1;
            bresp_next = cmma_pkg::RESP_SLVERR;
          end
        end
        cmma_pkg::A_CMD: begin
          if (busy) begin
            bresp_next = cmma_pkg::RESP_SLVERR;
          end else if (wstrb_reg[0] && wdata_reg[cmma_pkg::CMD_RELOAD]) begin
            start_load = 1'b1;
          end else if (wstrb_reg[0] && wdata_reg[cmma_pkg::CMD_READ]) begin
            state_next = cmma_pkg::S_HRD;
          end
        end
        cmma_pkg::A_STAT: begin
          if (wstrb_reg[0] && wdata_reg[cmma_pkg::ST_REJ]) begin
            rej_next = 1'b0;
          end
        end
        cmma_pkg::A_CFG: begin
        end
        default: bresp_next = cmma_pkg::RESP_SLVERR;
      endcase
    end

    if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_next = 1'b1;
      rresp_next = cmma_pkg::RESP_OKAY;
      rdata_next = 32'h0000_0000;
      case (s_axi_araddr_i)
        cmma_pkg::A_ADDR: rdata_next[9:0] = addr_reg;
        cmma_pkg::A_DATA: rdata_next[15:0] = rdbuf_reg;
        cmma_pkg::A_CMD: rdata_next = 32'h0000_0000;
        cmma_pkg::A_STAT: begin
          rdata_next[cmma_pkg::ST_BUSY] = busy;
          rdata_next[cmma_pkg::ST_DONE] = done_reg;
          rdata_next[cmma_pkg::ST_CSUM] = csum_reg;
          rdata_next[cmma_pkg::ST_REJ] = rej_reg;
        end
        cmma_pkg::A_CFG: rdata_next[23:0] = {inv_reg, pinfn_reg};
        default: rresp_next = cmma_pkg::RESP_SLVERR;
      endcase
    end

    if (load_busy) begin
      ld_cyc_next = 9'(ld_cyc_reg + 9'h001);
    end
    unique case (state_reg)
      cmma_pkg::S_IDLE: begin
      end
      cmma_pkg::S_HRD: begin
        rdbuf_next = mem_rdata;
        state_next = cmma_pkg::S_IDLE;
      end
      cmma_pkg::S_LRD: state_next = cmma_pkg::S_LACC;
      cmma_pkg::S_LACC: begin
        if (scan_reg == cmma_pkg::W_PINFN) begin
          pinfn_next = mem_rdata;
        end
        if (scan_reg == cmma_pkg::W_INV) begin
          inv_next = mem_rdata[7:0];
        end
        if (scan_reg == cmma_pkg::W_CSUM) begin
          csum_next = (sum_reg != mem_rdata);
          done_next = 1'b1;
          state_next = cmma_pkg::S_IDLE;
        end else begin
          if (cmma_pkg::in_cfg(scan_reg)) begin
            sum_next = 16'(sum_reg + mem_rdata);
          end
          scan_next = 10'(scan_reg + 10'h001);
          state_next = cmma_pkg::S_LRD;
        end
      end
    endcase

    // A USB reset mid-scan restarts the scan from word zero
    if (start_load || usb_reset_i) begin
      state_next = cmma_pkg::S_LRD;
      scan_next = 10'h000;
      sum_next = 16'h0000;
      done_next = 1'b0;
      ld_cyc_next = 9'h000;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_reg <= cmma_pkg::S_LRD;
      scan_reg <= 10'h000;
      sum_reg <= 16'h0000;
      pinfn_reg <= cmma_pkg::PINFN_RST;
      inv_reg <= cmma_pkg::INV_RST;
      done_reg <= 1'b0;
      csum_reg <= 1'b0;
      rej_reg <= 1'b0;
      addr_reg <= 10'h000;
      rdbuf_reg <= 16'h0000;
      aw_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
      ld_cyc_reg <= 9'h000;
    end else begin
      state_reg <= state_next;
      scan_reg <= scan_next;
      sum_reg <= sum_next;
      pinfn_reg <= pinfn_next;
      inv_reg <= inv_next;
      done_reg <= done_next;
      csum_reg <= csum_next;
      rej_reg <= rej_next;
      addr_reg <= addr_next;
      rdbuf_reg <= rdbuf_next;
      aw_hold_reg <= aw_hold_next;
      awaddr_reg <= awaddr_next;
      w_hold_reg <= w_hold_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      ld_cyc_reg <= ld_cyc_next;
    end
  end

  cmma_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(wdata_reg[15:0]),
    .rdata_o(mem_rdata)
  );

  // UART line polarity; pin inputs pass two flops first
  logic [4:0] sync1_reg, sync2_reg, min_reg, min_next;
  logic [2:0] pout_reg, pout_next;

  always_comb begin
    min_next = sync2_reg ^ {inv_reg[cmma_pkg::INV_RI], inv_reg[cmma_pkg::INV_DCD],
      inv_reg[cmma_pkg::INV_DSR], inv_reg[cmma_pkg::INV_CTS],
      inv_reg[cmma_pkg::INV_RXD]};
    pout_next = {core_dtr_n_i ^ inv_reg[cmma_pkg::INV_DTR],
      core_rts_n_i ^ inv_reg[cmma_pkg::INV_RTS],
      core_txd_i ^ inv_reg[cmma_pkg::INV_TXD]};
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      sync1_reg <= 5'h1f;
      sync2_reg <= 5'h1f;
      min_reg <= 5'h1f;
      pout_reg <= 3'h7;
    end else begin
      sync1_reg <= {ri_i, dcd_i, dsr_i, cts_i, rxd_i};
      sync2_reg <= sync1_reg;
      min_reg <= min_next;
      pout_reg <= pout_next;
    end
  end

  assign {core_ri_n_o, core_dcd_n_o, core_dsr_n_o, core_cts_n_o, core_rxd_o} = min_reg;
  assign {dtr_o, rts_o, txd_o} = pout_reg;

  cmma_pinmux u_pinmux (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .pinfn_i(pinfn_reg),
    .suspend_i(usb_suspend_i),
    .rs485_tx_enable_i(core_rs485_tx_enable_i),
    .rx_act_i(core_rx_act_i),
    .tx_act_i(core_tx_act_i),
    .pin_o(config_pin_group_o),
    .pin_oe_o(config_pin_group_oe_o)
  );

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_reserved_no_write: assert property (mem_we |-> !(mem_addr >= cmma_pkg::RSV_LO &&
    mem_addr <= cmma_pkg::RSV_HI)) else $error("Write reached a reserved word");
  a_user_write_taken: assert property ((do_wr && awaddr_reg == cmma_pkg::A_DATA && !busy &&
    wstrb_reg[1:0] == 2'h3 && addr_reg >= cmma_pkg::USER2_LO) |-> mem_we ##2 !bvalid_reg ||
    bresp_reg == cmma_pkg::RESP_OKAY) else $error("User area write not taken");
  a_cfg_write_taken: assert property ((do_wr && awaddr_reg == cmma_pkg::A_DATA && !busy &&
    wstrb_reg[1:0] == 2'h3 && addr_reg == cmma_pkg::W_PINFN) |-> mem_we)
    else $error("Config area write not taken");
  a_default_pins: assert property ($rose(rstn_i) |-> pinfn_reg == cmma_pkg::PINFN_RST &&
    inv_reg == 8'h00) else $error("Reset config not default");
  a_sleep_low: assert property ((pinfn_reg[15:12] == cmma_pkg::FN_SLEEP && usb_suspend_i)
    |=> config_pin_group_oe_o[3] && !config_pin_group_o[3]) else $error("Sleep pin not low");
  // First edge after release still shows the reset level, so skip it
  a_txd_invert: assert property ($past(rstn_i) |-> txd_o ==
    ($past(core_txd_i) ^ $past(inv_reg[cmma_pkg::INV_TXD]))) else $error("Transmit polarity wrong");
  a_cts_invert: assert property (##1 core_cts_n_o == ($past(sync2_reg[1]) ^
    $past(inv_reg[cmma_pkg::INV_CTS]))) else $error("CTS polarity wrong");
  a_reload_start: assert property (usb_reset_i |=> state_reg == cmma_pkg::S_LRD &&
    scan_reg == 10'h000 && !done_reg) else $error("USB reset did not reload");
  a_load_length: assert property ($fell(load_busy) |-> ld_cyc_reg == 9'(cmma_pkg::LOAD_CYCLES)
    && done_reg) else $error("Load scan length wrong");
  a_csum_flag: assert property ((state_reg == cmma_pkg::S_LACC && scan_reg == cmma_pkg::W_CSUM
    && !usb_reset_i) |=> csum_reg == ($past(sum_reg) != $past(mem_rdata)))
    else $error("Checksum flag wrong");

  c_load_done: cover property ($fell(load_busy));
  c_csum_bad: cover property ($rose(csum_reg));
  c_write_reject: cover property ($rose(rej_reg));
  c_host_read: cover property (state_reg == cmma_pkg::S_HRD ##1 rvalid_reg);
endmodule

/* tb/cmma_far_uart.sv */
`timescale 1ns/100ps
// Far serial device: echoes data and handshake, holds its status lines steady
module cmma_far_uart #(
  parameter logic DSR_LVL = 1'b1,
  parameter logic DCD_LVL = 1'b0,
  parameter logic RI_LVL = 1'b1
) (
  // From the bridge pins
  input wire logic dev_txd_i,
  input wire logic dev_rts_i,
  input wire logic dev_dtr_i,
  // To the bridge pins
  output logic dev_rxd_o,
  output logic dev_cts_o,
  output logic dev_dsr_o,
  output logic dev_dcd_o,
  output logic dev_ri_o
);
  // Loopback makes both inversions show up on one path
  assign dev_rxd_o = dev_txd_i;
  assign dev_cts_o = dev_rts_i;
  // Status lines ignore dtr so a stuck dtr_o stays visible
  assign dev_dsr_o = DSR_LVL;
  assign dev_dcd_o = DCD_LVL;
  assign dev_ri_o = RI_LVL;
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic usb_reset_i = 1'b0, usb_suspend_i = 1'b0;
  logic core_txd_i = 1'b0, core_rts_n_i = 1'b1, core_dtr_n_i = 1'b0;
  logic core_rs485_tx_enable_i = 1'b0, core_rx_act_i = 1'b0, core_tx_act_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
  logic [31:0] s_axi_rdata_o, rd;
  logic core_rxd_o, core_cts_n_o, core_dsr_n_o, core_dcd_n_o, core_ri_n_o;
  logic txd_o, rts_o, dtr_o, rxd_i, cts_i, dsr_i, dcd_i, ri_i;
  logic [3:0] config_pin_group_o, config_pin_group_oe_o;
  logic [15:0] v;
  logic [9:0] ua [4] = '{10'h012, 10'h03e, 10'h080, 10'h3ff};
  logic [9:0] ra [2] = '{10'h040, 10'h04e};
  int error_cnt = 0;
  int n_tests = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  cmma_top DUT (.ref_clk_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .usb_reset_i,
    .usb_suspend_i, .core_txd_i, .core_rxd_o, .core_rts_n_i, .core_dtr_n_i, .core_cts_n_o,
    .core_dsr_n_o, .core_dcd_n_o, .core_ri_n_o, .core_rs485_tx_enable_i, .core_rx_act_i,
    .core_tx_act_i, .txd_o, .rxd_i, .rts_o, .dtr_o, .cts_i, .dsr_i, .dcd_i, .ri_i,
    .config_pin_group_o, .config_pin_group_oe_o);

  cmma_far_uart FAR (.dev_txd_i(txd_o), .dev_rts_i(rts_o), .dev_dtr_i(dtr_o),
    .dev_rxd_o(rxd_i), .dev_cts_o(cts_i), .dev_dsr_o(dsr_i), .dev_dcd_o(dcd_i),
    .dev_ri_o(ri_i));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit pa, pw, pb;
    int t;
    pa = 1;
    pw = 1;
    pb = 1;
    t = 0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      t++;
      if (pa && s_axi_awready_o === 1'b1) begin
        s_axi_awvalid_i <= 1'b0;
        pa = 0;
      end
      if (pw && s_axi_wready_o === 1'b1) begin
        s_axi_wvalid_i <= 1'b0;
        pw = 0;
      end
      if (pb && s_axi_bvalid_o === 1'b1) begin
        // Ready stays up, so a following call never drops and raises it at once
        r = s_axi_bresp_o;
        pb = 0;
      end
    end while ((pa || pw || pb) && t < 200);
    if (t >= 200) chk(32'h0, 32'h1, "write hang");
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit pa, pr;
    int t;
    pa = 1;
    pr = 1;
    t = 0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      t++;
      if (pa && s_axi_arready_o === 1'b1) begin
        s_axi_arvalid_i <= 1'b0;
        pa = 0;
      end
      if (pr && s_axi_rvalid_o === 1'b1) begin
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        pr = 0;
      end
    end while ((pa || pr) && t < 200);
    if (t >= 200) chk(32'h0, 32'h1, "read hang");
  endtask

  // Polls status; a scan takes a few hundred cycles
  task automatic idle();
    int t;
    t = 0;
    do begin
      axr(cmma_pkg::A_STAT, rd, rs);
      t++;
    end while (rd[cmma_pkg::ST_BUSY] !== 1'b0 && t < 400);
    chk({31'h0, rd[cmma_pkg::ST_BUSY]}, 32'h0, "busy stuck");
  endtask

  task automatic mw(input logic [9:0] wa, input logic [15:0] d, output logic [1:0] r);
    axw(cmma_pkg::A_ADDR, {22'h0, wa}, r);
    axw(cmma_pkg::A_DATA, {16'h0, d}, r);
  endtask

  task automatic mr(input logic [9:0] wa, output logic [15:0] d);
    axw(cmma_pkg::A_ADDR, {22'h0, wa}, rs);
    axw(cmma_pkg::A_CMD, 32'h1, rs);
    idle();
    axr(cmma_pkg::A_DATA, rd, rs);
    d = rd[15:0];
  endtask

  task automatic pins(input logic [3:0] oe, input logic [3:0] lvl);
    repeat (2) @(posedge ref_clk_i);
    chk({28'h0, config_pin_group_oe_o}, {28'h0, oe}, "pin enable");
    chk({28'h0, config_pin_group_o & oe}, {28'h0, lvl & oe}, "pin level");
  endtask

  // Order: txd rts dtr rxd cts_n dsr_n dcd_n ri_n
  task automatic uart(input logic [7:0] exp);
    repeat (5) @(posedge ref_clk_i);
    chk({24'h0, txd_o, rts_o, dtr_o, core_rxd_o, core_cts_n_o, core_dsr_n_o, core_dcd_n_o,
      core_ri_n_o}, {24'h0, exp}, "uart lines");
  endtask

  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    idle();
    chk(rd, 32'h2, "status after load");
    axr(cmma_pkg::A_CFG, rd, rs);
    chk(rd, 32'h00004321, "default config");
    core_rs485_tx_enable_i <= 1'b1;
    core_rx_act_i <= 1'b1;
    usb_suspend_i <= 1'b1;
    pins(4'b1011, 4'b0001);
    core_rs485_tx_enable_i <= 1'b0;
    core_rx_act_i <= 1'b0;
    core_tx_act_i <= 1'b1;
    usb_suspend_i <= 1'b0;
    pins(4'b1101, 4'b1000);
    uart(8'b0100_1101);
    foreach (ua[i]) begin
      mw(ua[i], 16'ha500 ^ {6'h0, ua[i]}, rs);
      chk({30'h0, rs}, 32'h0, "user write resp");
      mr(ua[i], v);
      chk({16'h0, v}, {16'h0, 16'ha500 ^ {6'h0, ua[i]}}, "user readback");
    end
    axw(cmma_pkg::A_ADDR, 32'h12, rs);
    s_axi_wstrb_i <= 4'h1;
    axw(cmma_pkg::A_DATA, 32'h0, rs);
    s_axi_wstrb_i <= 4'hf;
    chk({30'h0, rs}, 32'h2, "partial data write");
    foreach (ra[i]) begin
      mw(ra[i], 16'hffff, rs);
      chk({30'h0, rs}, 32'h2, "reserved write resp");
      axr(cmma_pkg::A_STAT, rd, rs);
      chk(rd, 32'ha, "reject flag set");
      mr(ra[i], v);
      chk({16'h0, v}, 32'h0, "reserved unchanged");
    end
    axw(cmma_pkg::A_STAT, 32'h8, rs);
    axr(cmma_pkg::A_STAT, rd, rs);
    chk(rd, 32'h2, "reject flag cleared");
    axr(8'h14, rd, rs);
    chk({30'h0, rs}, 32'h2, "unmapped read resp");
    chk(rd, 32'h0, "unmapped read data");
    // Config words written on purpose only
    mw(cmma_pkg::W_PINFN, 16'h0076, rs);
    chk({30'h0, rs}, 32'h0, "config write resp");
    mw(cmma_pkg::W_INV, 16'h00ff, rs);
    chk({30'h0, rs}, 32'h0, "invert write resp");
    axw(cmma_pkg::A_CMD, 32'h2, rs);
    axw(cmma_pkg::A_DATA, 32'h1234, rs);
    chk({30'h0, rs}, 32'h2, "data write while busy");
    idle();
    chk(rd, 32'h6, "checksum mismatch flagged");
    axr(cmma_pkg::A_CFG, rd, rs);
    chk(rd, 32'h00ff0076, "loaded config");
    pins(4'b0011, 4'b0010);
    uart(8'b1010_1010);
    // User words excluded: sum is pin word plus invert word only
    mw(cmma_pkg::W_CSUM, 16'h0175, rs);
    chk({30'h0, rs}, 32'h0, "checksum write resp");
    usb_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    usb_reset_i <= 1'b0;
    idle();
    chk(rd, 32'h2, "checksum good after usb reset");
    summarize();
  end
endmodule
